// File: rtl/burst_gate_pkg.sv
/*
 Constants and types for the burst gate and colour standard decoder.
 Assumes one clock at four times the subcarrier and an active-low async reset.
*/
package burst_gate_pkg;
   localparam int       COUNT_W            = 9;
   localparam int       STD_BIT            = 7;
   localparam int       SYNC_W             = 3;
   localparam int       SYNC_CSYNC         = 0;
   localparam int       SYNC_BURST         = 1;
   localparam int       SYNC_STD           = 2;
   localparam logic [8:0] COUNT_MAX        = 9'h1ff;
   localparam logic [8:0] HALF_LINE_MIN    = 9'h0a0;
   localparam logic [8:0] STD_CHECK_COUNT  = 9'h040;
   localparam logic [8:0] NTSC_BURST_START = 9'h012;
   localparam logic [8:0] PAL_BURST_START  = 9'h018;
   localparam logic [8:0] NTSC_BURST_LEN   = 9'h009;
   localparam logic [8:0] PAL_BURST_LEN    = 9'h00a;
   localparam logic [8:0] NTSC_BURST_STOP  = NTSC_BURST_START + NTSC_BURST_LEN;
   localparam logic [8:0] PAL_BURST_STOP   = PAL_BURST_START + PAL_BURST_LEN;
   localparam logic [1:0] RING_RESET       = 2'h0;
   localparam logic [1:0] RING_TICK        = 2'h0;
   localparam logic       TIMING_NTSC_RST  = 1'h1;
   localparam logic [2:0] GATE_HIST_FULL   = 3'h7;

   typedef enum logic [1:0]
   {
      BURST_INTERNAL = 2'b00,
      BURST_SUPPRESS = 2'b01,
      BURST_EXTERNAL = 2'b10
   } burst_mode_t;
endpackage

// File: rtl/burst_gate_standard_decode.sv
/*
 Burst gate placement, colour standard decision and PAL phase switching.
 Assumes clk_in is the 4x subcarrier, negative composite sync on a pin,
 and an outside resolver for the burst-flag and standard-select pins.
*/
`timescale 1ns/1ps
module burst_gate_standard_decode
(
   input  wire logic clk_in,
   input  wire logic rst_b_in,
   input  wire logic csync_b_in,
   input  wire logic burst_flag_pin_in,
   output logic      burst_flag_pin_out,
   output logic      burst_flag_pin_oe_out,
   input  wire logic standard_select_pin_in,
   output logic      standard_select_pin_out,
   output logic      standard_select_pin_oe_out,
   output logic      subcarrier_i_out,
   output logic      subcarrier_q_out,
   output logic      sync_aligned_b_out,
   output logic      clamp_strobe_out,
   output logic      burst_gate_out,
   output logic      burst_b_env_out,
   output logic      burst_r_env_out,
   output logic      burst_r_invert_out,
   output logic      pal_mode_out,
   output logic      timing_ntsc_out
);
   typedef struct packed
   {
      logic                        sample;
      logic [8:0]                  count;
      logic                        line_armed;
      logic                        clamp_armed;
      logic                        clamp;
      logic                        gate;
      logic [2:0]                  gate_hist;
      logic                        timing_ntsc;
      logic                        pending_ntsc;
      burst_gate_pkg::burst_mode_t mode;
      logic                        ext_seen;
      logic                        probe_seen;
      logic                        burst;
      logic                        b_env;
      logic                        r_env;
      logic                        r_inv;
      logic                        pal_mode;
      logic                        square;
      logic                        force_seen;
   } state_t;

   localparam state_t RESET_STATE = '{
      sample:       1'b1,
      count:        burst_gate_pkg::COUNT_MAX,
      line_armed:   1'b0,
      clamp_armed:  1'b0,
      clamp:        1'b0,
      gate:         1'b0,
      gate_hist:    3'h0,
      timing_ntsc:  burst_gate_pkg::TIMING_NTSC_RST,
      pending_ntsc: burst_gate_pkg::TIMING_NTSC_RST,
      mode:         burst_gate_pkg::BURST_INTERNAL,
      ext_seen:     1'b0,
      probe_seen:   1'b0,
      burst:        1'b0,
      b_env:        1'b0,
      r_env:        1'b0,
      r_inv:        1'b0,
      pal_mode:     1'b0,
      square:       1'b0,
      force_seen:   1'b0
   };

   state_t                              s;
   state_t                              next_s;
   logic [burst_gate_pkg::SYNC_W-1:0]   raw_pins;
   logic [burst_gate_pkg::SYNC_W-1:0]   synced_pins;
   logic                                tick;
   logic                                csync_s;
   logic                                burst_pin_s;
   logic                                std_pin_s;
   logic                                lead_edge;
   logic                                accept;
   logic                                driving;
   logic                                guard;
   logic [8:0]                          burst_start;
   logic [8:0]                          burst_stop;

   assign raw_pins[burst_gate_pkg::SYNC_CSYNC] = csync_b_in;
   assign raw_pins[burst_gate_pkg::SYNC_BURST] = burst_flag_pin_in;
   assign raw_pins[burst_gate_pkg::SYNC_STD]   = standard_select_pin_in;

   pin_sync
   #(
      .WIDTH (burst_gate_pkg::SYNC_W)
   )
   u_pin_sync
   (
      .clk_in   (clk_in),
      .rst_b_in (rst_b_in),
      .pin_in   (raw_pins),
      .pin_out  (synced_pins)
   );

   ring_divider u_ring
   (
      .clk_in      (clk_in),
      .rst_b_in    (rst_b_in),
      .phase_i_out (subcarrier_i_out),
      .phase_q_out (subcarrier_q_out),
      .tick_out    (tick)
   );

   assign csync_s     = synced_pins[burst_gate_pkg::SYNC_CSYNC];
   assign burst_pin_s = synced_pins[burst_gate_pkg::SYNC_BURST];
   assign std_pin_s   = synced_pins[burst_gate_pkg::SYNC_STD];

   always_comb
   begin
      next_s      = s;
      lead_edge   = 1'b0;
      accept      = 1'b0;
      burst_start = s.timing_ntsc ? burst_gate_pkg::NTSC_BURST_START : burst_gate_pkg::PAL_BURST_START;
      burst_stop  = s.timing_ntsc ? burst_gate_pkg::NTSC_BURST_STOP : burst_gate_pkg::PAL_BURST_STOP;
      driving     = (s.mode != burst_gate_pkg::BURST_EXTERNAL);
      // Pin echo lags the drive by the synchroniser, so mask a few cycles
      guard       = s.gate | (|s.gate_hist);

      // Sync only moves on subcarrier ticks, giving one-subcarrier-period (four-clock) resolution
      if (tick)
      begin
         next_s.sample = csync_s;
         lead_edge     = s.sample & ~csync_s;
         // Half-line equalising pulses arrive with the count still low
         accept        = lead_edge & (s.count >= burst_gate_pkg::HALF_LINE_MIN);
         if (lead_edge)
         begin
            next_s.count = '0;
         end
         // Saturate, so a solid vertical block cannot wrap into a false line
         else if (s.count != burst_gate_pkg::COUNT_MAX)
         begin
            next_s.count = s.count + 9'h001;
         end
      end

      // Burst window measured from the accepted leading edge
      if (tick && s.line_armed)
      begin
         if ((s.count + 9'h001) == burst_start)
         begin
            next_s.gate = 1'b1;
         end
         if ((s.count + 9'h001) == burst_stop)
         begin
            next_s.gate       = 1'b0;
            next_s.line_armed = 1'b0;
         end
      end

      if (accept)
      begin
         next_s.line_armed  = 1'b1;
         next_s.gate        = 1'b0;
         next_s.clamp_armed = 1'b1;
         // A saturated count means no line was measured; keep the old choice
         if (s.count != burst_gate_pkg::COUNT_MAX)
         begin
            if (s.count[burst_gate_pkg::STD_BIT] == s.pending_ntsc)
            begin
               next_s.timing_ntsc = s.count[burst_gate_pkg::STD_BIT];
            end
            next_s.pending_ntsc = s.count[burst_gate_pkg::STD_BIT];
         end
         if (s.pal_mode)
         begin
            next_s.square = ~s.square;
         end
         // Line-end verdict on how the burst pin is being used
         case (s.mode)
            burst_gate_pkg::BURST_INTERNAL,
            burst_gate_pkg::BURST_SUPPRESS:
            begin
               if (s.ext_seen)
               begin
                  next_s.mode = burst_gate_pkg::BURST_EXTERNAL;
               end
               else if (s.probe_seen)
               begin
                  next_s.mode = burst_gate_pkg::BURST_INTERNAL;
               end
               else
               begin
                  next_s.mode = burst_gate_pkg::BURST_SUPPRESS;
               end
            end
            burst_gate_pkg::BURST_EXTERNAL:
            begin
               next_s.mode = s.ext_seen ? burst_gate_pkg::BURST_EXTERNAL : burst_gate_pkg::BURST_INTERNAL;
            end
            default:
            begin
               next_s.mode = burst_gate_pkg::BURST_INTERNAL;
            end
         endcase
         next_s.ext_seen   = 1'b0;
         next_s.probe_seen = 1'b0;
      end

      // Sightings taken after the clear, so a same-cycle one is kept
      if (burst_pin_s && (!driving || !guard))
      begin
         next_s.ext_seen = 1'b1;
      end
      if (burst_pin_s && s.gate && (s.gate_hist == burst_gate_pkg::GATE_HIST_FULL))
      begin
         next_s.probe_seen = 1'b1;
      end
      next_s.gate_hist = {s.gate_hist[1:0], s.gate};

      // Standard pin checked 64 ticks into the line, far from any squarewave transition
      if (tick && (s.count == burst_gate_pkg::STD_CHECK_COUNT))
      begin
         if (!s.pal_mode)
         begin
            if (std_pin_s)
            begin
               next_s.pal_mode   = 1'b1;
               next_s.square     = 1'b0;
               next_s.force_seen = 1'b0;
            end
         end
         else if (s.square)
         begin
            if (!std_pin_s)
            begin
               // One forced line resets phase; two in a row mean grounded
               if (s.force_seen)
               begin
                  next_s.pal_mode = 1'b0;
               end
               next_s.square     = 1'b0;
               next_s.force_seen = 1'b1;
            end
            else
            begin
               next_s.force_seen = 1'b0;
            end
         end
      end

      if (tick && csync_s)
      begin
         next_s.clamp_armed = 1'b0;
      end
      next_s.clamp = next_s.clamp_armed & ~next_s.sample;

      case (next_s.mode)
         burst_gate_pkg::BURST_INTERNAL: next_s.burst = next_s.gate;
         burst_gate_pkg::BURST_SUPPRESS: next_s.burst = 1'b0;
         burst_gate_pkg::BURST_EXTERNAL: next_s.burst = burst_pin_s;
         default:                        next_s.burst = 1'b0;
      endcase
      next_s.b_env = next_s.burst;
      next_s.r_env = next_s.burst & next_s.pal_mode;
      next_s.r_inv = next_s.pal_mode & next_s.square;
   end

   // Reset only parks the logic; the first accepted edge sets the line up
   always_ff @(posedge clk_in or negedge rst_b_in)
   begin
      if (!rst_b_in)
      begin
         s <= RESET_STATE;
      end
      else
      begin
         s <= next_s;
      end
   end

   assign burst_flag_pin_out         = s.gate;
   assign burst_flag_pin_oe_out      = (s.mode != burst_gate_pkg::BURST_EXTERNAL) & s.gate;
   assign standard_select_pin_out    = s.square;
   assign standard_select_pin_oe_out = s.pal_mode;
   assign sync_aligned_b_out         = s.sample;
   assign clamp_strobe_out           = s.clamp;
   assign burst_gate_out             = s.burst;
   assign burst_b_env_out            = s.b_env;
   assign burst_r_env_out            = s.r_env;
   assign burst_r_invert_out         = s.r_inv;
   assign pal_mode_out               = s.pal_mode;
   assign timing_ntsc_out            = s.timing_ntsc;
endmodule

// File: rtl/pin_sync.sv
/*
 Two-stage synchroniser for the pins that come from the video source.
 Assumes inputs are asynchronous to clk_in; only the second stage is read.
*/
`timescale 1ns/1ps
module pin_sync
#(
   parameter int WIDTH = 3
)
(
   input  wire logic             clk_in,
   input  wire logic             rst_b_in,
   input  wire logic [WIDTH-1:0] pin_in,
   output logic      [WIDTH-1:0] pin_out
);
   typedef struct packed
   {
      logic [WIDTH-1:0] first;
      logic [WIDTH-1:0] second;
   } sync_state_t;

   sync_state_t s;
   sync_state_t next_s;

   always_comb
   begin
      next_s        = s;
      next_s.first  = pin_in;
      next_s.second = s.first;
   end

   always_ff @(posedge clk_in or negedge rst_b_in)
   begin
      if (!rst_b_in)
      begin
         s <= '0;
      end
      else
      begin
         s <= next_s;
      end
   end

   assign pin_out = s.second;
endmodule

// File: rtl/ring_divider.sv
/*
 Johnson ring counter dividing the 4x clock into quadrature subcarriers.
 Assumes clk_in is the 4x subcarrier; tick marks one subcarrier period.
*/
`timescale 1ns/1ps
module ring_divider
(
   input  wire logic clk_in,
   input  wire logic rst_b_in,
   output logic      phase_i_out,
   output logic      phase_q_out,
   output logic      tick_out
);
   typedef struct packed
   {
      logic [1:0] ring;
      logic       tick;
   } ring_state_t;

   ring_state_t s;
   ring_state_t next_s;

   // Johnson sequence keeps the two phases exactly 90 degrees apart
   always_comb
   begin
      next_s      = s;
      next_s.ring = {s.ring[0], ~s.ring[1]};
      next_s.tick = (next_s.ring == burst_gate_pkg::RING_TICK);
   end

   always_ff @(posedge clk_in or negedge rst_b_in)
   begin
      if (!rst_b_in)
      begin
         s <= '{ring: burst_gate_pkg::RING_RESET, tick: 1'b0};
      end
      else
      begin
         s <= next_s;
      end
   end

   assign phase_i_out = s.ring[1];
   assign phase_q_out = s.ring[0];
   assign tick_out    = s.tick;
endmodule

// File: tb/burst_gate_props.sv
/*
 Port checker for the burst gate decoder, bound to its top module.
 Assumes one 4x subcarrier clock and an active-low async reset.
*/
`timescale 1ns/1ps
module burst_gate_props
(
   input wire logic clk_in,
   input wire logic rst_b_in,
   input wire logic burst_flag_pin_out,
   input wire logic burst_flag_pin_oe_out,
   input wire logic standard_select_pin_out,
   input wire logic standard_select_pin_oe_out,
   input wire logic subcarrier_i_out,
   input wire logic subcarrier_q_out,
   input wire logic sync_aligned_b_out,
   input wire logic clamp_strobe_out,
   input wire logic burst_gate_out,
   input wire logic burst_b_env_out,
   input wire logic burst_r_env_out,
   input wire logic burst_r_invert_out,
   input wire logic pal_mode_out,
   input wire logic timing_ntsc_out
);
   logic [9:0] gate_len;
   logic [9:0] since_clamp;
   logic       clamp_q;
   default clocking cb @(posedge clk_in);
   endclocking
   default disable iff (!rst_b_in);
   // Counters wrap on long lines; only short windows after sync are judged
   always_ff @(posedge clk_in or negedge rst_b_in)
   begin
      if (!rst_b_in)
      begin
         gate_len    <= 10'h000;
         since_clamp <= 10'h000;
         clamp_q     <= 1'h0;
      end
      else
      begin
         gate_len    <= burst_gate_out ? gate_len + 10'h001 : 10'h000;
         since_clamp <= (clamp_strobe_out && !clamp_q) ? 10'h001 : since_clamp + 10'h001;
         clamp_q     <= clamp_strobe_out;
      end
   end
   chk_blue_env_gate: assert property (burst_b_env_out == burst_gate_out)
      else $error("blue envelope differs from gate");
   chk_red_env_pal: assert property (burst_r_env_out == (burst_gate_out && pal_mode_out))
      else $error("red envelope not gate in pal");
   chk_red_inv_square: assert property (burst_r_env_out |-> burst_r_invert_out == standard_select_pin_out)
      else $error("red inversion not following squarewave");
   chk_square_oe_pal: assert property (standard_select_pin_oe_out == pal_mode_out)
      else $error("standard pin drive not matching mode");
   chk_flag_oe_high: assert property (burst_flag_pin_oe_out |-> burst_flag_pin_out)
      else $error("burst pin driven while gate low");
   chk_gate_len_std: assert property ($fell(burst_gate_out) && $past(burst_flag_pin_oe_out) |->
      gate_len == (timing_ntsc_out ? 10'h024 : 10'h028))
      else $error("internal gate length wrong");
   chk_gate_start_std: assert property ($rose(burst_gate_out) ##1 burst_flag_pin_oe_out |->
      (timing_ntsc_out ? since_clamp inside {[69:75]} : since_clamp inside {[93:99]}))
      else $error("internal gate start wrong");
   chk_clamp_in_sync: assert property ($rose(clamp_strobe_out) |-> !sync_aligned_b_out)
      else $error("clamp outside sync");
   chk_clamp_release: assert property ($rose(sync_aligned_b_out) |-> ##[0:2] !clamp_strobe_out)
      else $error("clamp held after sync");
   chk_sync_tick_rate: assert property ($changed(sync_aligned_b_out) |=> $stable(sync_aligned_b_out)[*3])
      else $error("aligned sync not on subcarrier tick");
   chk_quad_period: assert property ($rose(subcarrier_i_out) |=>
      subcarrier_i_out ##1 (!subcarrier_i_out)[*2] ##1 subcarrier_i_out)
      else $error("subcarrier period not four clocks");
   chk_quad_step: assert property ($changed(subcarrier_i_out) |-> $stable(subcarrier_q_out))
      else $error("subcarrier phases not in quadrature");
endmodule
bind burst_gate_standard_decode burst_gate_props u_props
(
   .clk_in(clk_in), .rst_b_in(rst_b_in), .burst_flag_pin_out(burst_flag_pin_out),
   .burst_flag_pin_oe_out(burst_flag_pin_oe_out), .standard_select_pin_out(standard_select_pin_out),
   .standard_select_pin_oe_out(standard_select_pin_oe_out), .subcarrier_i_out(subcarrier_i_out),
   .subcarrier_q_out(subcarrier_q_out), .sync_aligned_b_out(sync_aligned_b_out),
   .clamp_strobe_out(clamp_strobe_out), .burst_gate_out(burst_gate_out),
   .burst_b_env_out(burst_b_env_out), .burst_r_env_out(burst_r_env_out),
   .burst_r_invert_out(burst_r_invert_out), .pal_mode_out(pal_mode_out),
   .timing_ntsc_out(timing_ntsc_out)
);

// File: tb/tb.sv
/*
 Self-checking bench for burst_gate_standard_decode.
 Assumes a pull-down on the burst pin and a pull-up on the standard pin.
*/
`timescale 1ns/1ps
module tb;
   logic        clk_in, rst_b_in, csync_b, run, blk, bf_en, bf_val, sp_low;
   logic        bf_pin, sp_pin, bf_out, bf_oe, sp_out, sp_oe, clamp, gate, b_env, r_env, pal, t_ntsc;
   logic [11:0] line_len, sync_len;
   logic [2:0]  mid;
   int          n_mismatch, cmp_count, off, wid, sq, ngate, w;
   assign bf_pin = bf_en ? bf_val : (bf_oe & bf_out);
   assign sp_pin = sp_low ? 1'h0 : (sp_oe ? sp_out : 1'h1);
   video_source src (.clk_in(clk_in), .run_in(run), .block_in(blk), .line_len_in(line_len),
                     .sync_len_in(sync_len), .csync_b_out(csync_b));
   burst_gate_standard_decode dut
   (
      .clk_in(clk_in), .rst_b_in(rst_b_in), .csync_b_in(csync_b),
      .burst_flag_pin_in(bf_pin), .burst_flag_pin_out(bf_out), .burst_flag_pin_oe_out(bf_oe),
      .standard_select_pin_in(sp_pin), .standard_select_pin_out(sp_out),
      .standard_select_pin_oe_out(sp_oe), .subcarrier_i_out(), .subcarrier_q_out(),
      .sync_aligned_b_out(), .clamp_strobe_out(clamp), .burst_gate_out(gate),
      .burst_b_env_out(b_env), .burst_r_env_out(r_env), .burst_r_invert_out(),
      .pal_mode_out(pal), .timing_ntsc_out(t_ntsc)
   );
   initial
   begin
      clk_in = 1'h0;
      forever #20 clk_in = ~clk_in;
   end
   task automatic tick();
      @(posedge clk_in);
      #2;
   endtask
   task automatic tally_and_finish();
      if (n_mismatch == 0 && cmp_count > 0)
         $display("Result: passed");
      else
         $display("Result: failed");
      $finish;
   endtask
   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      cmp_count++;
      if (seen !== exp)
      begin
         n_mismatch++;
         $display("CHECK FAILED at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask
   // Bounded: a lost sync ends the run instead of hanging it
   task automatic wait_lines(input int n);
      int t;
      t = 0;
      repeat (n)
      begin
         while (clamp !== 1'h0 && t < 8000)
         begin
            tick();
            t++;
         end
         while (clamp !== 1'h1 && t < 8000)
         begin
            tick();
            t++;
         end
      end
      if (t >= 8000)
      begin
         n_mismatch++;
         tally_and_finish();
      end
   endtask
   task automatic gate_span();
      off = 0;
      wid = 0;
      while (gate !== 1'h1 && off < 2000)
      begin
         tick();
         off++;
      end
      while (gate === 1'h1 && wid < 2000)
      begin
         if (wid == 4)
            mid = {bf_out, b_env, r_env};
         tick();
         wid++;
      end
      if (off >= 2000 || wid >= 2000)
      begin
         n_mismatch++;
         tally_and_finish();
      end
   endtask
   task automatic count_gate(input int n);
      ngate = 0;
      repeat (n)
      begin
         tick();
         if (gate !== 1'h0)
            ngate++;
      end
   endtask
   // Model: count at line end, bit for fsc/256, picks burst timing
   task automatic check_internal(input logic pal_exp);
      int tk;
      tk = ((line_len / 4) >> 7) & 1;
      wait_lines(1);
      gate_span();
      check((off + 2) / 4, tk ? 18 : 24);
      check(wid, tk ? 36 : 40);
      check(t_ntsc, tk);
      check(pal, pal_exp);
      check(sp_oe, pal_exp);
      check(mid, {2'h3, pal_exp});
   endtask
   task automatic ext_pulse(input int n);
      repeat (300) tick();
      bf_val = 1'h1;
      repeat (n) tick();
      bf_val = 1'h0;
   endtask
   initial
   begin
      {rst_b_in, run, blk, bf_en, bf_val, sp_low} = 6'h01;
      line_len = 12'h38e;
      sync_len = 12'h040;
      {n_mismatch, cmp_count, sq, mid} = '0;
      void'($urandom(78890));
      repeat (12) tick();
      rst_b_in = 1'h1;
      run = 1'h1;
      sync_len = 12'h038 + 12'($urandom_range(16));
      wait_lines(4);
      check_internal(1'h0);
      blk = 1'h1;
      repeat (2730) tick();
      blk = 1'h0;
      wait_lines(3);
      check_internal(1'h0);
      sp_low = 1'h0;
      line_len = 12'h46f;
      wait_lines(4);
      check_internal(1'h1);
      repeat (2)
         if (sp_out !== 1'h1)
            wait_lines(1);
      sp_low = 1'h1;
      repeat (400) tick();
      sp_low = 1'h0;
      check(sp_out, 0);
      check(pal, 1);
      repeat (3)
      begin
         wait_lines(1);
         repeat (8) tick();
         sq ^= 1;
         check(sp_out, sq);
      end
      line_len = 12'h237;
      repeat (200) tick();
      count_gate(4000);
      check(ngate, 0);
      check(sp_out, sq);
      line_len = 12'h38e;
      sp_low = 1'h1;
      wait_lines(6);
      check_internal(1'h0);
      {bf_en, bf_val} = 2'h2;
      wait_lines(3);
      count_gate(1800);
      check(ngate, 0);
      w = 30 + $urandom_range(30);
      // First pulse only earns the external verdict; no gate shows on that line
      wait_lines(1);
      ext_pulse(w);
      repeat (3)
      begin
         wait_lines(1);
         fork
            ext_pulse(w);
            gate_span();
         join
      end
      check((off - 298) / 4, 1);
      check(wid, w);
      tally_and_finish();
   end
endmodule

// File: tb/video_source.sv
/*
 Video source model: composite sync lines, halved lines and block sync.
 Assumes the bench sets line and sync lengths in clocks.
*/
`timescale 1ns/1ps
module video_source
(
   input  wire logic        clk_in,
   input  wire logic        run_in,
   input  wire logic        block_in,
   input  wire logic [11:0] line_len_in,
   input  wire logic [11:0] sync_len_in,
   output logic             csync_b_out
);
   int pos;
   initial
   begin
      pos = 0;
      csync_b_out = 1'h1;
   end
   // Moves just after the edge, never on it
   always @(posedge clk_in)
   begin
      #2;
      pos = (pos + 1 >= line_len_in) ? 0 : pos + 1;
      csync_b_out = !run_in ? 1'h1 : (block_in ? 1'h0 : (pos >= sync_len_in));
   end
endmodule
